// ==== verilog/twa_arbiter.sv ====
// Secondary bus time-based weighted round robin arbiter with traffic class windows
`timescale 1ns/100ps
module twa_arbiter
#(
   parameter int PHASE_CLKS = twa_pkg::PHASE_CYCLES
)
(
   input wire logic CLK_SYS, // System clock
   input wire logic RST_B, // Asynchronous reset, active low
   input wire logic CFG_SPACE, // 0 extended config space, 1 memory window
   input wire logic CFG_WR, // Register write strobe
   input wire logic CFG_RD, // Register read strobe
   input wire logic [11:0] CFG_ADDR, // Register byte address
   input wire logic [31:0] CFG_WDATA, // Register write data
   output logic [31:0] CFG_RDATA, // Register read data
   output logic CFG_RVALID, // Read data valid pulse
   input wire logic INT_REQ, // Internal master request
   output logic INT_GNT, // Internal master grant
   input wire logic [5:0] REQ_B, // External requests, active low pins
   output logic [5:0] GNT_B, // External grants, active low pins
   input wire logic FRAME_B, // Bus frame pin, active low
   input wire logic IRDY_B, // Bus initiator ready pin, active low
   input wire logic US_VALID, // Upstream memory write present
   input wire logic [31:0] US_ADDR, // Upstream memory write address
   output logic US_TC_VALID, // Traffic class result valid
   output logic [2:0] US_TC // Traffic class label
);
   // ****************************************
   // Reset release
   // ****************************************
   logic [1:0] rst_sync_ff;
   logic rst_n;
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         rst_sync_ff <= 2'h0;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end
   assign rst_n = rst_sync_ff[1];

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [7:0] pin_s1_ff;
   logic [7:0] pin_s2_ff;
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_ff <= 8'hFF;
         pin_s2_ff <= 8'hFF;
      end
      else
      begin
         pin_s1_ff <= {IRDY_B, FRAME_B, REQ_B};
         pin_s2_ff <= pin_s1_ff;
      end
   end

   logic [twa_pkg::NUM_PORTS-1:0] req_vec;
   logic bus_busy;
   assign req_vec = {~pin_s2_ff[5:0], INT_REQ};
   assign bus_busy = ~pin_s2_ff[6] | ~pin_s2_ff[7];

   // ****************************************
   // Register file
   // ****************************************
   logic [31:0] isoc_ctrl_ff;
   logic [31:0] res_ctrl_ff;
   logic table_status_ff;
   logic [31:0] cfg_tab_ff [twa_pkg::TABLE_WORDS];
   logic [31:0] int_tab_ff [twa_pkg::TABLE_WORDS];
   logic [31:0] win_ctrl_ff [twa_pkg::NUM_WIN];
   logic [31:0] win_base_ff [twa_pkg::NUM_WIN];
   logic [31:0] win_limit_ff [twa_pkg::NUM_WIN];
   logic wr_cfg;
   logic wr_mem;
   logic tab_hit;
   logic [3:0] tab_idx;
   logic load_cmd;

   assign wr_cfg = CFG_WR && !CFG_SPACE;
   assign wr_mem = CFG_WR && CFG_SPACE;
   assign tab_hit = (CFG_ADDR >= twa_pkg::OFS_TABLE_FIRST) && (CFG_ADDR <= twa_pkg::OFS_TABLE_LAST)
      && (CFG_ADDR[1:0] == 2'h0);
   assign tab_idx = CFG_ADDR[5:2];
   assign load_cmd = wr_cfg && (CFG_ADDR == twa_pkg::OFS_RES_CTRL)
      && CFG_WDATA[twa_pkg::BIT_TABLE_LOAD];

   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         isoc_ctrl_ff <= twa_pkg::RESET_WORD;
      else if (wr_mem && (CFG_ADDR == twa_pkg::OFS_ISOC_CTRL))
         isoc_ctrl_ff <= CFG_WDATA;
   end

   // Load bit is a command, never stored
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         res_ctrl_ff <= twa_pkg::RESET_WORD;
      else if (wr_cfg && (CFG_ADDR == twa_pkg::OFS_RES_CTRL))
      begin
         res_ctrl_ff <= CFG_WDATA;
         res_ctrl_ff[twa_pkg::BIT_TABLE_LOAD] <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < twa_pkg::TABLE_WORDS; i++)
            cfg_tab_ff[i] <= twa_pkg::RESET_WORD;
      end
      else if (wr_cfg && tab_hit)
         cfg_tab_ff[tab_idx] <= CFG_WDATA;
   end

   // internal table changes only on load
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < twa_pkg::TABLE_WORDS; i++)
            int_tab_ff[i] <= twa_pkg::RESET_WORD;
      end
      else if (load_cmd)
      begin
         for (int i = 0; i < twa_pkg::TABLE_WORDS; i++)
            int_tab_ff[i] <= cfg_tab_ff[i];
      end
   end

   // modified flag, a write beats a load
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         table_status_ff <= 1'b0;
      else if (wr_cfg && tab_hit)
         table_status_ff <= 1'b1;
      else if (load_cmd)
         table_status_ff <= 1'b0;
   end

   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < twa_pkg::NUM_WIN; i++)
         begin
            win_ctrl_ff[i] <= twa_pkg::RESET_WORD;
            win_base_ff[i] <= twa_pkg::RESET_WORD;
            win_limit_ff[i] <= twa_pkg::RESET_WORD;
         end
      end
      else if (wr_mem)
      begin
         for (int i = 0; i < twa_pkg::NUM_WIN; i++)
         begin
            if (CFG_ADDR == twa_pkg::OFS_WIN0_CTRL + 12'(i) * twa_pkg::OFS_WIN_STRIDE)
               win_ctrl_ff[i] <= CFG_WDATA;
            else if (CFG_ADDR == twa_pkg::OFS_WIN0_BASE + 12'(i) * twa_pkg::OFS_WIN_STRIDE)
               win_base_ff[i] <= CFG_WDATA;
            else if (CFG_ADDR == twa_pkg::OFS_WIN0_LIMIT + 12'(i) * twa_pkg::OFS_WIN_STRIDE)
               win_limit_ff[i] <= CFG_WDATA;
         end
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   logic [31:0] nxt_rdata;
   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      if (CFG_SPACE)
      begin
         if (CFG_ADDR == twa_pkg::OFS_ISOC_CTRL)
            nxt_rdata = isoc_ctrl_ff;
         for (int i = 0; i < twa_pkg::NUM_WIN; i++)
         begin
            if (CFG_ADDR == twa_pkg::OFS_WIN0_CTRL + 12'(i) * twa_pkg::OFS_WIN_STRIDE)
               nxt_rdata = win_ctrl_ff[i];
            else if (CFG_ADDR == twa_pkg::OFS_WIN0_BASE + 12'(i) * twa_pkg::OFS_WIN_STRIDE)
               nxt_rdata = win_base_ff[i];
            else if (CFG_ADDR == twa_pkg::OFS_WIN0_LIMIT + 12'(i) * twa_pkg::OFS_WIN_STRIDE)
               nxt_rdata = win_limit_ff[i];
         end
      end
      else if (CFG_ADDR == twa_pkg::OFS_RES_CTRL)
         nxt_rdata = res_ctrl_ff;
      else if (CFG_ADDR == twa_pkg::OFS_RES_STATUS)
         nxt_rdata[twa_pkg::BIT_TABLE_STATUS] = table_status_ff;
      else if (tab_hit)
         nxt_rdata = cfg_tab_ff[tab_idx];
   end

   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         CFG_RDATA <= 32'h0000_0000;
         CFG_RVALID <= 1'b0;
      end
      else
      begin
         CFG_RVALID <= CFG_RD;
         if (CFG_RD)
            CFG_RDATA <= nxt_rdata;
      end
   end

   // ****************************************
   // Mode select
   // ****************************************
   twa_pkg::twa_mode_t mode;
   logic wrr_sel;
   assign wrr_sel = isoc_ctrl_ff[twa_pkg::BIT_TIME_EN]
      && (res_ctrl_ff[twa_pkg::SEL_MSB:twa_pkg::SEL_LSB] == twa_pkg::SEL_WRR128);
   assign mode = !wrr_sel ? twa_pkg::MODE_CLASSIC :
      (isoc_ctrl_ff[twa_pkg::BIT_AGGR_EN] ? twa_pkg::MODE_AGGR : twa_pkg::MODE_TIMED);

   // ****************************************
   // Phase timer
   // ****************************************
   logic [15:0] div_ff;
   logic phase_tick;
   logic [6:0] phase_ff;
   assign phase_tick = (div_ff == 16'(PHASE_CLKS - 1));
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         div_ff <= 16'h0000;
      else if (phase_tick || (mode == twa_pkg::MODE_CLASSIC))
         div_ff <= 16'h0000;
      else
         div_ff <= div_ff + 16'h0001;
   end

   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         phase_ff <= 7'h00;
      else if (mode == twa_pkg::MODE_CLASSIC)
         phase_ff <= 7'h00;
      else if (phase_tick)
         phase_ff <= phase_ff + 7'h01;
   end

   // ****************************************
   // Grant decision
   // ****************************************
   logic [3:0] entry;
   logic [twa_pkg::NUM_PORTS-1:0] sched;
   logic [twa_pkg::NUM_PORTS-1:0] gnt_ff;
   logic [twa_pkg::NUM_PORTS-1:0] nxt_gnt;
   logic owner_busy;

   assign entry = int_tab_ff[phase_ff[6:3]]
      [phase_ff[2:0]*twa_pkg::ENTRY_BITS +: twa_pkg::ENTRY_BITS];

   // reserved or idle port gets none
   always_comb
   begin
      sched = '0;
      if ((entry <= twa_pkg::PORT_LAST_VALID) && req_vec[entry[2:0]])
         sched[entry[2:0]] = 1'b1;
   end

   assign owner_busy = |(gnt_ff & req_vec) || ((gnt_ff != '0) && bus_busy);

   always_comb
   begin
      nxt_gnt = '0;
      case (mode)
         twa_pkg::MODE_CLASSIC:
         begin
            if (owner_busy)
               nxt_gnt = gnt_ff;
            else
               nxt_gnt = req_vec & (~req_vec + 7'h01);
         end
         twa_pkg::MODE_TIMED:
         begin
            if (owner_busy && (sched != gnt_ff))
               nxt_gnt = bus_busy ? gnt_ff : '0;
            else
               nxt_gnt = sched;
         end
         twa_pkg::MODE_AGGR:
         begin
            nxt_gnt = sched;
         end
         default:
            nxt_gnt = '0;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gnt_ff <= '0;
         INT_GNT <= 1'b0;
         GNT_B <= 6'h3F;
      end
      else
      begin
         gnt_ff <= nxt_gnt;
         INT_GNT <= nxt_gnt[0];
         GNT_B <= ~nxt_gnt[6:1];
      end
   end

   // ****************************************
   // Upstream traffic class windows
   // ****************************************
   twa_win_if wif();
   assign wif.addr = US_ADDR;
   always_comb
   begin
      for (int i = 0; i < twa_pkg::NUM_WIN; i++)
      begin
         wif.ctrl[i] = win_ctrl_ff[i];
         wif.base[i] = win_base_ff[i];
         wif.limit[i] = win_limit_ff[i];
      end
   end

   for (genvar g = 0; g < twa_pkg::NUM_WIN; g++)
   begin : g_win
      twa_window #(.IDX(g)) u_win (.wif(wif));
   end

   logic [2:0] nxt_tc;
   always_comb
   begin
      nxt_tc = twa_pkg::TC_DEFAULT;
      for (int i = twa_pkg::NUM_WIN - 1; i >= 0; i--)
      begin
         if (wif.hit[i])
            nxt_tc = {2'h0, wif.tc_bit[i]};
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         US_TC <= twa_pkg::TC_DEFAULT;
         US_TC_VALID <= 1'b0;
      end
      else
      begin
         US_TC_VALID <= US_VALID;
         if (US_VALID)
            US_TC <= nxt_tc;
      end
   end
endmodule

// ==== verilog/twa_pkg.sv ====
// Constants shared by the time-based arbiter and its window matchers
package twa_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [11:0] OFS_ISOC_CTRL = 12'h004;
   localparam logic [11:0] OFS_WIN0_CTRL = 12'h008;
   localparam logic [11:0] OFS_WIN0_BASE = 12'h00C;
   localparam logic [11:0] OFS_WIN0_LIMIT = 12'h010;
   localparam logic [11:0] OFS_WIN_STRIDE = 12'h00C;
   localparam logic [11:0] OFS_VC_CAP = 12'h150;
   localparam logic [11:0] OFS_RES_CTRL = 12'h170;
   localparam logic [11:0] OFS_RES_STATUS = 12'h176;
   localparam logic [11:0] OFS_TABLE_FIRST = 12'h1C0;
   localparam logic [11:0] OFS_TABLE_LAST = 12'h1FC;
   // ****************************************
   // Field positions and codes
   // ****************************************
   localparam int BIT_TIME_EN = 1;
   localparam int BIT_AGGR_EN = 2;
   localparam int BIT_TABLE_LOAD = 16;
   localparam int SEL_LSB = 17;
   localparam int SEL_MSB = 19;
   localparam logic [2:0] SEL_WRR128 = 3'h4;
   localparam int BIT_TABLE_STATUS = 0;
   localparam int WIN_EN_LSB = 1;
   localparam int WIN_EN_MSB = 3;
   localparam int BIT_WIN_TC = 0;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   // ****************************************
   // Table and port geometry
   // ****************************************
   localparam int NUM_WIN = 4;
   localparam int NUM_EXT = 6;
   localparam int NUM_PORTS = 7;
   localparam int TABLE_WORDS = 16;
   localparam int ENTRY_BITS = 4;
   localparam int ENTRIES_PER_WORD = 8;
   localparam int NUM_PHASES = 128;
   localparam logic [3:0] PORT_LAST_VALID = 4'h6;
   localparam logic [2:0] TC_DEFAULT = 3'h0;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 5;
   localparam int PHASE_NS = 80;
   localparam int PHASE_CYCLES = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ****************************************
   // Arbitration modes
   // ****************************************
   typedef enum logic [2:0]
   {
      MODE_CLASSIC = 3'b001,
      MODE_TIMED = 3'b010,
      MODE_AGGR = 3'b100
   } twa_mode_t;
endpackage

// ==== verilog/twa_win_if.sv ====
// Carrier between the arbiter top and its address window matchers
`timescale 1ns/100ps
interface twa_win_if;
   logic [31:0] addr;
   logic [31:0] ctrl [twa_pkg::NUM_WIN];
   logic [31:0] base [twa_pkg::NUM_WIN];
   logic [31:0] limit [twa_pkg::NUM_WIN];
   logic [twa_pkg::NUM_WIN-1:0] hit;
   logic [twa_pkg::NUM_WIN-1:0] tc_bit;
   modport top (output addr, ctrl, base, limit, input hit, tc_bit);
   modport win (input addr, ctrl, base, limit, output hit, tc_bit);
endinterface

// ==== verilog/twa_window.sv ====
// One upstream traffic class window: address range compare
`timescale 1ns/100ps
module twa_window
#(
   parameter int IDX = 0
)
(
   twa_win_if.win wif // Window settings and match result
);
   logic enabled;
   // ****************************************
   // Range compare
   // ****************************************
   // enable field gates mapping
   assign enabled = |wif.ctrl[IDX][twa_pkg::WIN_EN_MSB:twa_pkg::WIN_EN_LSB];
   assign wif.hit[IDX] = enabled && (wif.addr >= wif.base[IDX]) && (wif.addr <= wif.limit[IDX]);
   assign wif.tc_bit[IDX] = wif.ctrl[IDX][twa_pkg::BIT_WIN_TC];
endmodule

// ==== bench/twa_arbiter_checker.sv ====
// Port-level assertions for the time-based arbiter
`timescale 1ns/100ps
module twa_arbiter_checker
#(
   parameter int PHASE_CLKS = 16
)
(
   input wire logic CLK_SYS, // Clock
   input wire logic RST_B, // Reset, active low
   input wire logic CFG_SPACE, // Space select
   input wire logic CFG_WR, // Write strobe
   input wire logic CFG_RD, // Read strobe
   input wire logic [11:0] CFG_ADDR, // Address
   input wire logic [31:0] CFG_WDATA, // Write data
   input wire logic [31:0] CFG_RDATA, // Read data
   input wire logic CFG_RVALID, // Read valid
   input wire logic INT_REQ, // Internal request
   input wire logic INT_GNT, // Internal grant
   input wire logic [5:0] REQ_B, // Requests
   input wire logic [5:0] GNT_B, // Grants
   input wire logic FRAME_B, // Frame
   input wire logic IRDY_B, // Initiator ready
   input wire logic US_VALID, // Upstream write
   input wire logic [31:0] US_ADDR, // Upstream address
   input wire logic US_TC_VALID, // Class valid
   input wire logic [2:0] US_TC // Class
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_B);
   sequence s_rd(sp, ad);
      CFG_RD && (CFG_SPACE == sp) && (CFG_ADDR == ad);
   endsequence
   sequence s_new_ext;
      |($past(GNT_B) & ~GNT_B);
   endsequence
   // ****
   // Register port
   // ****
   rd_answer_a: assert property (CFG_RD |=> CFG_RVALID)
      else $error("read not answered");
   rd_pulse_a: assert property (!CFG_RD |=> !CFG_RVALID)
      else $error("read valid without read");
   rdata_hold_a: assert property (!CFG_RD |=> $stable(CFG_RDATA))
      else $error("read data moved");
   load_reads0_a: assert property (s_rd(1'b0, twa_pkg::OFS_RES_CTRL) |=> !CFG_RDATA[16])
      else $error("load bit read back set");
   hole_zero_a: assert property (s_rd(1'b0, 12'h174) |=> CFG_RDATA == 32'h0000_0000)
      else $error("unmapped read not zero");
   // ****
   // Grants and classes
   // ****
   tc_answer_a: assert property (US_VALID |=> US_TC_VALID && US_TC[2:1] == 2'h0)
      else $error("class answer wrong");
   one_grant_a: assert property ($countones({INT_GNT, ~GNT_B}) <= 1)
      else $error("several grants");
   ext_cause_a: assert property (s_new_ext |->
      ($past(GNT_B) & ~GNT_B & $past(REQ_B, 3)) == 6'h00)
      else $error("grant without request");
   int_cause_a: assert property ($rose(INT_GNT) |-> $past(INT_REQ))
      else $error("internal grant without request");
   reset_idle_a: assert property ($rose(RST_B) |=>
      GNT_B == 6'h3F && !INT_GNT ##1 !CFG_RVALID)
      else $error("outputs busy after reset");
endmodule

// ==== bench/twa_pci_masters.sv ====
// Six external bus masters facing the arbiter
`timescale 1ns/100ps
module twa_pci_masters
(
   input wire logic clk, // Bus clock
   input wire logic [5:0] want, // Masters wanting the bus
   input wire logic hold, // Keep bus busy
   input wire logic [5:0] gnt_b, // Grants
   output logic [5:0] req_b, // Requests
   output logic frame_b, // Frame
   output logic irdy_b // Initiator ready
);
   logic [1:0] beat_ff = 2'h0;
   logic [5:0] last_ff = 6'h3F;
   assign req_b = ~want;
   assign frame_b = ~(hold || (beat_ff != 2'h0));
   assign irdy_b = frame_b;
   // One short transfer per grant
   always_ff @(posedge clk)
   begin
      if (beat_ff != 2'h0)
      begin
         beat_ff <= beat_ff - 2'h1;
      end
      if (gnt_b == 6'h3F)
      begin
         last_ff <= 6'h3F;
      end
      else if (beat_ff == 2'h0 && frame_b && gnt_b != last_ff && |(~gnt_b & want))
      begin
         last_ff <= gnt_b;
         beat_ff <= 2'h2;
      end
   end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the time-based arbiter
`timescale 1ns/100ps
module testbench;
   localparam int PCLK = 4;
   logic CLK_SYS = 1'b0;
   logic RST_B = 1'b0;
   logic CFG_SPACE = 1'b0;
   logic CFG_WR = 1'b0;
   logic CFG_RD = 1'b0;
   logic [11:0] CFG_ADDR = 12'h000;
   logic [31:0] CFG_WDATA = 32'h0;
   logic [31:0] CFG_RDATA;
   logic CFG_RVALID;
   logic INT_REQ = 1'b0;
   logic INT_GNT;
   logic [5:0] REQ_B;
   logic [5:0] GNT_B;
   logic FRAME_B;
   logic IRDY_B;
   logic US_VALID = 1'b0;
   logic [31:0] US_ADDR = 32'h0;
   logic US_TC_VALID;
   logic [2:0] US_TC;
   logic [5:0] want = 6'h00;
   logic hold = 1'b0;
   logic [6:0] seen;
   int n_mismatch = 0;
   int n_tests = 0;
   always #2.5 CLK_SYS = ~CLK_SYS;
   twa_arbiter #(.PHASE_CLKS(PCLK)) dut_u (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
      .CFG_SPACE(CFG_SPACE), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR),
      .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID),
      .INT_REQ(INT_REQ), .INT_GNT(INT_GNT), .REQ_B(REQ_B), .GNT_B(GNT_B),
      .FRAME_B(FRAME_B), .IRDY_B(IRDY_B), .US_VALID(US_VALID), .US_ADDR(US_ADDR),
      .US_TC_VALID(US_TC_VALID), .US_TC(US_TC));
   twa_pci_masters mst_u (.clk(CLK_SYS), .want(want), .hold(hold), .gnt_b(GNT_B),
      .req_b(REQ_B), .frame_b(FRAME_B), .irdy_b(IRDY_B));
   // ****
   // Tasks
   // ****
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cfg_wr(input logic sp, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLK_SYS);
      CFG_SPACE <= sp;
      CFG_ADDR <= a;
      CFG_WDATA <= d;
      CFG_WR <= 1'b1;
      @(posedge CLK_SYS);
      CFG_WR <= 1'b0;
   endtask
   task automatic rd_chk(input logic sp, input logic [11:0] a, input logic [31:0] exp);
      @(posedge CLK_SYS);
      CFG_SPACE <= sp;
      CFG_ADDR <= a;
      CFG_RD <= 1'b1;
      @(posedge CLK_SYS);
      CFG_RD <= 1'b0;
      #1;
      check("read valid", CFG_RVALID, 1'b1);
      check("read data", CFG_RDATA, exp);
   endtask
   task automatic us_chk(input logic [31:0] a, input logic [2:0] exp);
      @(posedge CLK_SYS);
      US_ADDR <= a;
      US_VALID <= 1'b1;
      @(posedge CLK_SYS);
      US_VALID <= 1'b0;
      #1;
      check("class", {US_TC_VALID, US_TC}, {1'b1, exp});
   endtask
   task automatic set_bus(input logic [5:0] w, input logic h, input logic ir, input int n);
      @(posedge CLK_SYS);
      want <= w;
      hold <= h;
      INT_REQ <= ir;
      seen = 7'h00;
      repeat (n + 8)
      begin
         @(posedge CLK_SYS);
         #1;
         if (n == 0 || seen !== 7'h7F)
            seen = (seen == 7'h7F) ? 7'h00 : seen | {INT_GNT, ~GNT_B};
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ****
   // Sequence
   // ****
   initial
   begin
      repeat (10000) @(posedge CLK_SYS);
      n_mismatch++;
      stop_test();
   end
   initial
   begin
      repeat (6) @(posedge CLK_SYS);
      RST_B <= 1'b1;
      repeat (3) @(posedge CLK_SYS);
      rd_chk(1'b1, twa_pkg::OFS_ISOC_CTRL, 32'h0); // mode off
      set_bus(6'h04, 1'b0, 1'b0, 8);
      check("classic", seen, 7'h04); // classic grant
      cfg_wr(1'b0, twa_pkg::OFS_RES_CTRL, 32'h0008_0000);
      set_bus(6'h04, 1'b0, 1'b1, 60);
      check("select only", seen, 7'h04); // still classic
      for (int w = 0; w < 16; w++)
         cfg_wr(1'b0, 12'h1C0 + 12'(4 * w), (w == 0) ? 32'hFF11_1222 : 32'hFFFF_FFFF);
      rd_chk(1'b0, 12'h1C0, 32'hFF11_1222); // first word
      rd_chk(1'b0, 12'h1FC, 32'hFFFF_FFFF); // last word
      rd_chk(1'b0, twa_pkg::OFS_RES_STATUS, 32'h1); // pending
      rd_chk(1'b0, 12'h174, 32'h0); // hole
      cfg_wr(1'b1, twa_pkg::OFS_ISOC_CTRL, 32'h2);
      set_bus(6'h23, 1'b0, 1'b1, 600);
      check("old table", seen, 7'h40); // old table
      cfg_wr(1'b0, twa_pkg::OFS_RES_CTRL, 32'h0009_0000);
      rd_chk(1'b0, twa_pkg::OFS_RES_STATUS, 32'h0); // loaded
      rd_chk(1'b0, twa_pkg::OFS_RES_CTRL, 32'h0008_0000); // select kept
      set_bus(6'h23, 1'b0, 1'b1, 600);
      check("new table", seen, 7'h03); // schedule
      // Start the busy run at the head of a fresh grant
      for (int i = 0; i < 600 && GNT_B !== 6'h3F; i++) @(posedge CLK_SYS);
      for (int i = 0; i < 600 && GNT_B === 6'h3F; i++) @(posedge CLK_SYS);
      set_bus(6'h23, 1'b1, 1'b1, 600);
      check("timed busy", $countones(seen), 32'd1); // owner kept
      cfg_wr(1'b1, twa_pkg::OFS_ISOC_CTRL, 32'h6);
      set_bus(6'h23, 1'b1, 1'b1, 600);
      check("aggressive", seen, 7'h03); // preempt
      cfg_wr(1'b1, 12'h008, 32'h3);
      cfg_wr(1'b1, 12'h00C, 32'h1000);
      cfg_wr(1'b1, 12'h010, 32'h1FFC);
      cfg_wr(1'b1, 12'h02C, 32'h3);
      cfg_wr(1'b1, 12'h030, 32'h8000);
      cfg_wr(1'b1, 12'h034, 32'h8FFC);
      rd_chk(1'b1, 12'h00C, 32'h1000); // base
      us_chk(32'h0FFC, 3'h0); // below base
      us_chk(32'h1000, 3'h1); // at base
      us_chk(32'h1FFC, 3'h1); // at limit
      us_chk(32'h2000, 3'h0); // above limit
      us_chk(32'h8004, 3'h1); // fourth window
      cfg_wr(1'b1, 12'h008, 32'h1);
      us_chk(32'h1000, 3'h0); // window off
      stop_test();
   end
endmodule
bind twa_arbiter twa_arbiter_checker #(.PHASE_CLKS(PHASE_CLKS)) chk_u (.CLK_SYS(CLK_SYS),
   .RST_B(RST_B), .CFG_SPACE(CFG_SPACE), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD),
   .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
   .CFG_RVALID(CFG_RVALID), .INT_REQ(INT_REQ), .INT_GNT(INT_GNT), .REQ_B(REQ_B),
   .GNT_B(GNT_B), .FRAME_B(FRAME_B), .IRDY_B(IRDY_B), .US_VALID(US_VALID),
   .US_ADDR(US_ADDR), .US_TC_VALID(US_TC_VALID), .US_TC(US_TC));
